/* File: ssr_host.sv */
`timescale 1ns/1ps
module ssr_host
	import ssr_pkg::*;
#(
	parameter int RAM_WAIT  = RAM_READY_CYC,
	parameter int NV_WAIT   = NV_READY_CYC,
	parameter int SAVE_WAIT = SAVE_CYC
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rstn,
	// Supply monitor pin, high while supply is good
	input  wire logic              power_good,
	// User request side
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire ssr_req_t          req,
	output logic                   rsp_valid,
	output logic [DATA_W-1:0]      rsp_rdata,
	// Status
	output logic                   busy,
	output logic                   nv_ready,
	output logic                   write_seen,
	// Memory pins
	output logic [ADDR_W-1:0]      addr_lines,
	output ssr_ctl_t               ctl,
	input  wire logic [DATA_W-1:0] bidir_data_lines_i,
	output logic [DATA_W-1:0]      bidir_data_lines_o,
	output logic                   bidir_data_lines_oe
);
	ssr_state_t        state;
	ssr_state_t        next_state;
	logic              pg;
	logic              pg_d;
	logic [CNT_W-1:0]  pu_cnt;
	logic [CNT_W-1:0]  save_cnt;
	logic [1:0]        phase;
	logic              cur_wr;
	logic [DATA_W-1:0] rd_sync1;

	// Power-good from a pin: three-flop chain plus a filtered level flop
	ssr_sync #(.INIT(1'b0)) u_pg_sync (
		.clk   (clk),
		.rstn  (rstn),
		.pin   (power_good),
		.level (pg)
	);

	always_ff @(posedge clk) begin
		if (!rstn) pg_d <= 1'b0;
		else       pg_d <= pg;
	end

	// Time since power became good; saturates at the nonvolatile wait
	always_ff @(posedge clk) begin
		if (!rstn || !pg) begin
			pu_cnt <= '0;
		end else if (pu_cnt < CNT_W'(NV_WAIT)) begin
			pu_cnt <= pu_cnt + 1'b1;
		end
	end

	// Nonvolatile ready only after the long wait
	always_ff @(posedge clk) begin
		if (!rstn || !pg) nv_ready <= 1'b0;
		else              nv_ready <= (pu_cnt >= CNT_W'(NV_WAIT));
	end

	// Save window after a power-loss edge that follows a seen write; accesses stay blocked
	always_ff @(posedge clk) begin
		if (!rstn) begin
			save_cnt <= '0;
		end else if (pg_d && !pg && write_seen) begin
			save_cnt <= CNT_W'(SAVE_WAIT);
		end else if (save_cnt != '0) begin
			save_cnt <= save_cnt - 1'b1;
		end
	end

	// Tracks whether the memory would save at power loss
	always_ff @(posedge clk) begin
		if (!rstn) begin
			write_seen <= 1'b0;
		end else if (state == ST_ACCESS && cur_wr && phase == PH_STROBE) begin
			write_seen <= 1'b1; // Set wins over a same-cycle power-up clear
		end else if (pg && !pg_d) begin
			write_seen <= 1'b0;
		end
	end

	// State sequencing
	always_comb begin
		next_state = state;
		case (state)
			ST_WAIT_PU: begin
				// RAM usable only after its wait
				if (pg && pu_cnt >= CNT_W'(RAM_WAIT) && save_cnt == '0)
					next_state = ST_IDLE;
			end
			ST_IDLE: begin
				if (!pg)
					next_state = ST_POWERDN;
				else if (req_valid)
					next_state = ST_ACCESS;
			end
			ST_ACCESS: begin
				if (phase == PH_DONE)
					next_state = ST_RESP;
			end
			ST_RESP: begin
				next_state = pg ? ST_IDLE : ST_POWERDN;
			end
			ST_POWERDN: begin
				next_state = ST_WAIT_PU;
			end
			default: next_state = ST_WAIT_PU;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) state <= ST_WAIT_PU;
		else       state <= next_state;
	end

	// Access phase counter: setup, strobe, release
	always_ff @(posedge clk) begin
		if (!rstn || state != ST_ACCESS) phase <= PH_IDLE;
		else if (phase != PH_DONE)       phase <= phase + 2'h1;
	end

	// Latch request on acceptance
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cur_wr             <= 1'b0;
			addr_lines         <= '0;
			bidir_data_lines_o <= '0;
		end else if (state == ST_IDLE && next_state == ST_ACCESS) begin
			cur_wr             <= req.wr;
			addr_lines         <= req.addr;
			bidir_data_lines_o <= req.wdata;
		end
	end

	// Control pins; gate high by default, so only a read in progress at power loss blocks a save
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctl                 <= CTL_IDLE;
			bidir_data_lines_oe <= 1'b0;
		end else begin
			ctl                 <= CTL_IDLE;
			bidir_data_lines_oe <= 1'b0;
			if (state == ST_ACCESS && next_state == ST_ACCESS && pg) begin
				ctl.chip_sel_n <= 1'b0;
				if (cur_wr) begin
					// Write drives data, gate held high
					bidir_data_lines_oe <= 1'b1;
					ctl.wr_strobe_n     <= !(phase == PH_SETUP);
				end else begin
					ctl.out_gate_n <= 1'b0;
				end
			end
		end
	end

	// Read capture at strobe end; data already floated by device otherwise
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rd_sync1  <= '0;
			rsp_rdata <= '0;
		end else begin
			rd_sync1 <= bidir_data_lines_i;
			if (state == ST_ACCESS && phase == PH_DONE && !cur_wr)
				rsp_rdata <= rd_sync1;
		end
	end

	// Handshakes; busy covers power-up, save window and accesses
	assign req_ready = (state == ST_IDLE) && pg;
	assign rsp_valid = (state == ST_RESP);
	assign busy      = (state != ST_IDLE) || (save_cnt != '0);

	a_no_fight: assert property (@(posedge clk) disable iff (!rstn)
		!(bidir_data_lines_oe && !ctl.chip_sel_n && !ctl.out_gate_n))
		else $error("host drives data during read");
	a_cs_access: assert property (@(posedge clk) disable iff (!rstn)
		(!ctl.out_gate_n || !ctl.wr_strobe_n) |-> !ctl.chip_sel_n)
		else $error("strobe without chip select");
	a_no_both: assert property (@(posedge clk) disable iff (!rstn)
		!(!ctl.out_gate_n && !ctl.wr_strobe_n))
		else $error("gate and write strobe low together");
	a_save_block: assert property (@(posedge clk) disable iff (!rstn)
		(save_cnt != '0) |-> ctl.chip_sel_n)
		else $error("access during save");
	a_gate_idle: assert property (@(posedge clk) disable iff (!rstn)
		(state == ST_IDLE) |-> ctl.out_gate_n)
		else $error("gate low while idle");
	a_ram_wait: assert property (@(posedge clk) disable iff (!rstn)
		$rose(req_ready) |-> pu_cnt >= CNT_W'(RAM_WAIT))
		else $error("ready before RAM wait");
	a_nv_wait: assert property (@(posedge clk) disable iff (!rstn)
		nv_ready |-> pu_cnt >= CNT_W'(NV_WAIT))
		else $error("nv ready too early");
	a_write_pulse: assert property (@(posedge clk) disable iff (!rstn)
		$fell(ctl.wr_strobe_n) |=> ctl.wr_strobe_n && !ctl.chip_sel_n)
		else $error("write strobe not one cycle");
	a_resp_after: assert property (@(posedge clk) disable iff (!rstn)
		(state == ST_IDLE && req_valid && pg) |-> ##5 rsp_valid)
		else $error("response not in five cycles");

endmodule : ssr_host

/* File: ssr_pkg.sv */
package ssr_pkg;

	// Bus widths of the shadowed memory
	localparam int ADDR_W = 11;
	localparam int DATA_W = 8;

	// Power-up waits, figures as printed, converted at 100 MHz
	localparam int CLK_PERIOD_NS          = 10;
	localparam int RAM_READY_US           = 100;
	localparam int NV_READY_MS            = 5;
	localparam int RAM_READY_CYC          = RAM_READY_US * 1000 / CLK_PERIOD_NS;
	localparam int NV_READY_CYC           = NV_READY_MS * 1000000 / CLK_PERIOD_NS;
	// Longest save after power loss, tenths of a millisecond
	localparam int SAVE_TIME_TENTH_MS     = 25;
	localparam int SAVE_CYC               = SAVE_TIME_TENTH_MS * 100000 / CLK_PERIOD_NS;

	// Strobe timing in cycles: setup, active, recovery
	localparam logic [1:0] PH_SETUP  = 2'h1;
	localparam logic [1:0] PH_STROBE = 2'h2;
	localparam logic [1:0] PH_DONE   = 2'h3;
	localparam logic [1:0] PH_IDLE   = 2'h0;

	localparam int CNT_W = 24;

	// Request from the user side
	typedef struct packed {
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ssr_req_t;

	// Control pins toward the memory, all active low
	typedef struct packed {
		logic chip_sel_n;
		logic out_gate_n;
		logic wr_strobe_n;
	} ssr_ctl_t;

	localparam ssr_ctl_t CTL_IDLE = '{chip_sel_n: 1'b1, out_gate_n: 1'b1,
		wr_strobe_n: 1'b1};

	// Host states
	typedef enum logic [4:0] {
		ST_WAIT_PU  = 5'h01,
		ST_IDLE     = 5'h02,
		ST_ACCESS   = 5'h04,
		ST_POWERDN  = 5'h08,
		ST_RESP     = 5'h10
	} ssr_state_t;

endpackage : ssr_pkg

/* File: ssr_sync.sv */
`timescale 1ns/1ps
// Three-stage pin synchroniser; a change counts when stages two and three agree
module ssr_sync
	import ssr_pkg::*;
#(
	parameter logic INIT = 1'b0
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Pin and result
	input  wire logic pin,
	output logic      level
);
	logic s1;
	logic s2;
	logic s3;

	// Shift chain; s1 is only read by s2
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Filtered level moves only once two stages agree
	always_ff @(posedge clk) begin
		if (!rstn) begin
			level <= INIT;
		end else if (s2 == s3) begin
			level <= s3;
		end
	end

endmodule : ssr_sync

/* File: ssr_mem_model.sv */
`timescale 1ns/1ps
// Behavioural shadowed memory standing on the far side of the host
module ssr_mem_model
	import ssr_pkg::*;
(
	// Supply and pins
	input  wire logic              power_good,
	input  wire ssr_ctl_t          ctl,
	input  wire logic [ADDR_W-1:0] addr_lines,
	// Host drive and resolved wire
	input  wire logic [DATA_W-1:0] host_d,
	input  wire logic              host_oe,
	output logic [DATA_W-1:0]      wire_d,
	// Status for the bench
	output int                     save_cnt = 0,
	output logic                   clash = 1'b0
);
	logic [DATA_W-1:0] ram [2**ADDR_W];
	logic [DATA_W-1:0] shadow [2**ADDR_W];
	logic              dirty = 1'b0;
	logic              drv;

	// Drive only when selected and gated, nothing below the supply limit
	assign drv = power_good && !ctl.chip_sel_n && !ctl.out_gate_n;
	// Released lines show the inverse so a stale byte never passes
	always_comb begin
		if (host_oe)
			wire_d = host_d;
		else
			wire_d = drv ? ram[addr_lines] : ~ram[addr_lines];
	end
	// Sticky flag when both parties drive
	always @* if (host_oe && drv) clash = 1'b1;
	// Shadow holds a known pattern before first power-up
	initial for (int i = 0; i < 2**ADDR_W; i++) shadow[i] = i[7:0] ^ 8'h5A;
	// Whole-array recall at power-up, dirty flag cleared
	always @(posedge power_good) begin
		for (int i = 0; i < 2**ADDR_W; i++) ram[i] = shadow[i];
		dirty = 1'b0;
	end
	// Whole-array save on supply loss, only after a write, not while gated
	always @(negedge power_good) if (dirty && ctl.out_gate_n) begin
		for (int i = 0; i < 2**ADDR_W; i++) shadow[i] = ram[i];
		save_cnt++;
	end
	// Store at end of strobe; any count, ignored without supply
	always @(posedge ctl.wr_strobe_n) begin
		if (power_good && !ctl.chip_sel_n && ctl.out_gate_n) begin
			ram[addr_lines] = wire_d;
			dirty = 1'b1;
		end
	end
endmodule : ssr_mem_model

/* File: shadowed_sram_store_recall_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	error_cnt++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module shadowed_sram_store_recall_tb;
	import ssr_pkg::*;
	logic        clk = 0, rstn = 0, power_good = 0, req_valid = 0;
	ssr_req_t    req = '0;
	logic        req_ready, rsp_valid, busy, nv_ready, write_seen, oe;
	logic [7:0]  rdata, d_o, d_i, exp_mem [2048];
	logic [10:0] addr;
	ssr_ctl_t    ctl;
	logic [31:0] rng = 61997, r;
	logic        clash;
	int          save_cnt, saves = 0, error_cnt = 0, cmp_count = 0;

	always #5 clk = ~clk;
	// Short waits keep the power sequences brief
	ssr_host #(.RAM_WAIT(20), .NV_WAIT(50), .SAVE_WAIT(40)) uut (.clk(clk),
		.rstn(rstn), .power_good(power_good), .req_valid(req_valid),
		.req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
		.rsp_rdata(rdata), .busy(busy), .nv_ready(nv_ready),
		.write_seen(write_seen), .addr_lines(addr), .ctl(ctl),
		.bidir_data_lines_i(d_i), .bidir_data_lines_o(d_o),
		.bidir_data_lines_oe(oe));
	ssr_mem_model mem (.power_good(power_good), .ctl(ctl), .addr_lines(addr),
		.host_d(d_o), .host_oe(oe), .wire_d(d_i), .save_cnt(save_cnt),
		.clash(clash));

	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs
	task automatic end_of_test();
		$display("counts: %0d compared, %0d mismatched", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	// A used-up bound is a hang
	task automatic lim(input int i, input int m);
		if (i >= m) begin
			error_cnt++;
			$display("MISMATCH wait exp done got timeout");
			end_of_test();
		end
	endtask : lim
	// One access: wait for ready, offer for one cycle, wait for the answer
	task automatic op(input logic w, input logic [10:0] a, input logic [7:0] d);
		int i;
		i = 0;
		do begin @(negedge clk); i++; end while (req_ready !== 1'b1 && i < 100);
		lim(i, 100);
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{wr: w, addr: a, wdata: d};
		@(posedge clk);
		req_valid <= 1'b0;
		i = 0;
		do begin
			@(negedge clk);
			i++;
			if (ctl.chip_sel_n === 1'b0) `CHK("addr", a, addr)
		end while (rsp_valid !== 1'b1 && i < 20);
		lim(i, 20);
		if (!w) `CHK("rdata", exp_mem[a], rdata)
		else exp_mem[a] = d;
		@(negedge clk);
		`CHK("pulse", 1'b0, rsp_valid)
	endtask : op
	task automatic power_up();
		int i;
		@(posedge clk);
		power_good <= 1'b1;
		i = 0;
		do begin @(negedge clk); i++; end while (req_ready !== 1'b1 && i < 300);
		lim(i, 300);
		`CHK("ram_wait", 1'b1, i >= 20)
		`CHK("nv_early", 1'b0, nv_ready)
		`CHK("fresh", 1'b0, write_seen)
		do begin @(negedge clk); i++; end while (nv_ready !== 1'b1 && i < 300);
		lim(i, 300);
		`CHK("nv_wait", 1'b1, i >= 50)
	endtask : power_up
	task automatic power_down();
		@(posedge clk);
		power_good <= 1'b0;
		repeat (6) @(negedge clk);
		`CHK("busy", 1'b1, busy)
		`CHK("refuse", 1'b0, req_ready)
		`CHK("gate", 1'b1, ctl.out_gate_n)
		`CHK("saves", saves, save_cnt)
		repeat (60) @(negedge clk);
	endtask : power_down

	initial begin
		for (int i = 0; i < 2048; i++) exp_mem[i] = i[7:0] ^ 8'h5A;
		repeat (4) @(posedge clk);
		@(negedge clk);
		`CHK("idle_ctl", CTL_IDLE, ctl)
		`CHK("idle_oe", 1'b0, oe)
		@(posedge clk);
		rstn <= 1'b1;
		power_up();
		op(1'b0, 11'h000, 8'h00);
		op(1'b0, 11'h7FF, 8'h00);
		$display("test recall done");
		op(1'b1, 11'h7FF, 8'hFF);
		op(1'b1, 11'h000, 8'h00);
		for (int n = 0; n < 60; n++) begin
			r = xs();
			op(r[20], {7'h00, r[3:0]}, r[15:8]);
		end
		`CHK("wseen", 1'b1, write_seen)
		$display("test access done");
		saves = 1;
		power_down();
		power_up();
		for (int a = 0; a < 16; a++) op(1'b0, a[10:0], 8'h00);
		op(1'b0, 11'h7FF, 8'h00);
		`CHK("wclean", 1'b0, write_seen)
		$display("test save done");
		power_down();
		power_up();
		`CHK("clash", 1'b0, clash)
		$display("test clean power cycle done");
		end_of_test();
	end
endmodule : shadowed_sram_store_recall_tb
